// >>> rtl/ddc_pkg.sv
// Shared constants and types of the dual converter load and reference control
`default_nettype none
package ddc_pkg;
    // Serial frame shape
    localparam int          FRAME_BITS   = 24;
    localparam int          CMD_MSB      = 21;
    localparam int          CMD_LSB      = 19;
    localparam int          ADDR_MSB     = 18;
    localparam int          ADDR_LSB     = 16;
    localparam int          DATA_BITS    = 16;
    localparam logic [4:0]  LAST_BIT_IDX = 5'h17;

    // Command field codes
    localparam logic [2:0]  CMD_WRITE_INPUT = 3'h0;
    localparam logic [2:0]  CMD_LOAD_MASK   = 3'h6;
    localparam logic [2:0]  CMD_REF_SETUP   = 3'h7;

    // Channel select codes, channel A is index 0, channel B index 1
    localparam int          CHANNELS     = 2;
    localparam logic [2:0]  ADDR_ALL     = 3'h7;
    localparam logic [1:0][2:0] CH_ADDR  = {3'h1, 3'h0};

    // Field positions and reset values
    localparam int          MASK_LSB     = 0;
    localparam int          REF_BIT      = 0;
    localparam logic [1:0]  MASK_RESET   = 2'h0;
    localparam logic        REF_RESET    = 1'h0;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'h0,
        RX_SHIFT = 2'h1,
        RX_DONE  = 2'h3
    } ddc_rx_state_t;

    typedef struct packed {
        logic [2:0]           cmd;
        logic [2:0]           addr;
        logic [DATA_BITS-1:0] data;
    } ddc_frame_t;
endpackage
`default_nettype wire

// >>> rtl/ddc_serial_rx.sv
// Serial frame receiver: pin synchronisers, falling-edge shift and frame abort
`default_nettype none
module ddc_serial_rx (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            arst_n,
    input  wire logic            clkEn,
    // Serial pins
    input  wire logic            frameSyncN,
    input  wire logic            serialClk,
    input  wire logic            serialData,
    // Received frame
    output logic                 frameValid,
    output ddc_pkg::ddc_frame_t  frame
);
    typedef struct packed {
        logic [1:0]                     fsSync;
        logic [1:0]                     clkSync;
        logic [1:0]                     dinSync;
        logic                           clkPrev;
        ddc_pkg::ddc_rx_state_t         st;
        logic [4:0]                     bitCount;
        logic [ddc_pkg::FRAME_BITS-1:0] shift;
        logic                           valid;
    } ddc_rx_t;

    ddc_rx_t q;
    ddc_rx_t d;
    logic    clkFall;

    assign clkFall = q.clkPrev & ~q.clkSync[1];

    always_comb begin
        d         = q;
        d.fsSync  = {q.fsSync[0], frameSyncN};
        d.clkSync = {q.clkSync[0], serialClk};
        d.dinSync = {q.dinSync[0], serialData};
        d.clkPrev = q.clkSync[1];
        d.valid   = 1'b0;
        if (q.fsSync[1]) begin
            // Frame sync high: idle or abort, the partial word is dropped
            d.st       = ddc_pkg::RX_IDLE;
            d.bitCount = 5'h00;
            d.shift    = '0;
        end else begin
            unique case (q.st)
                ddc_pkg::RX_IDLE, ddc_pkg::RX_SHIFT: begin
                    d.st = ddc_pkg::RX_SHIFT;
                    if (clkFall) begin
                        // Most significant bit arrives first
                        d.shift    = {q.shift[ddc_pkg::FRAME_BITS-2:0], q.dinSync[1]};
                        d.bitCount = q.bitCount + 5'h01;
                        if (q.bitCount == ddc_pkg::LAST_BIT_IDX) begin
                            d.st    = ddc_pkg::RX_DONE;
                            d.valid = 1'b1;
                        end
                    end
                end
                ddc_pkg::RX_DONE: begin
                    // Extra edges after the last bit are ignored until sync rises
                    d.st = ddc_pkg::RX_DONE;
                end
                default: begin
                    d.st = ddc_pkg::RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{fsSync: 2'h3, clkSync: 2'h0, dinSync: 2'h0, clkPrev: 1'b0,
                   st: ddc_pkg::RX_IDLE, bitCount: 5'h00, shift: '0, valid: 1'b0};
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign frameValid = q.valid;
    assign frame      = ddc_pkg::ddc_frame_t'(q.shift[ddc_pkg::CMD_MSB:0]);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_abort_clears: assert property (
        (clkEn && q.fsSync[1]) |=> (q.bitCount == 5'h00 && q.st == ddc_pkg::RX_IDLE && !q.valid))
        else $error("frame not discarded on early sync rise");

    a_valid_at_last: assert property (
        $rose(q.valid) |-> ($past(q.bitCount) == ddc_pkg::LAST_BIT_IDX && $past(clkFall)))
        else $error("frame completed at wrong edge count");

    c_frame_done: cover property (q.valid);
    c_frame_abort: cover property (clkEn && q.fsSync[1] && q.st == ddc_pkg::RX_SHIFT);
endmodule
`default_nettype wire

// >>> rtl/ddc_load_ctrl.sv
// Double-buffered code registers with load pin, load mask and reference enable
`default_nettype none
module ddc_load_ctrl #(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input  wire logic                                  mclk,
    input  wire logic                                  arst_n,
    input  wire logic                                  clkEn,
    // Serial link pins
    input  wire logic                                  frameSyncN,
    input  wire logic                                  serialClk,
    input  wire logic                                  serialData,
    // Hardware load pin
    input  wire logic                                  loadPinN,
    // Converter codes and controls
    output logic [ddc_pkg::CHANNELS-1:0][DATA_W-1:0]   dacCode,
    output logic [ddc_pkg::CHANNELS-1:0]               loadMask,
    output logic                                       refEnable
);
    if (DATA_W < 1 || DATA_W > ddc_pkg::DATA_BITS) begin : g_check
        $error("DATA_W must lie between 1 and the frame data width");
    end

    typedef struct packed {
        logic [1:0]                                  loadSync;
        logic [ddc_pkg::CHANNELS-1:0]                mask;
        logic                                        refEn;
        logic [ddc_pkg::CHANNELS-1:0]                written;
        logic [ddc_pkg::CHANNELS-1:0][DATA_W-1:0]    inputCode;
        logic [ddc_pkg::CHANNELS-1:0][DATA_W-1:0]    dacCode;
    } ddc_ctrl_t;

    ddc_ctrl_t                                q;
    ddc_ctrl_t                                d;
    logic                                     frameValid;
    ddc_pkg::ddc_frame_t                      frame;
    logic                                     loadHigh;
    logic [DATA_W-1:0]                        newCode;
    logic [ddc_pkg::CHANNELS-1:0]             writeHit;
    logic [ddc_pkg::CHANNELS-1:0]             doUpdate;
    logic [ddc_pkg::CHANNELS-1:0]             writtenNext;
    logic [ddc_pkg::CHANNELS-1:0][DATA_W-1:0] inputNext;
    logic [ddc_pkg::CHANNELS-1:0][DATA_W-1:0] dacNext;

    ddc_serial_rx u_rx (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .clkEn      (clkEn),
        .frameSyncN (frameSyncN),
        .serialClk  (serialClk),
        .serialData (serialData),
        .frameValid (frameValid),
        .frame      (frame)
    );

    assign loadHigh = q.loadSync[1];
    assign newCode  = frame.data[ddc_pkg::DATA_BITS-1 -: DATA_W];

    for (genvar ch = 0; ch < ddc_pkg::CHANNELS; ch++) begin : g_chan
        // Channel A answers address 0, channel B address 1, both answer all
        assign writeHit[ch] = frameValid && frame.cmd == ddc_pkg::CMD_WRITE_INPUT &&
                              (frame.addr == ddc_pkg::CH_ADDR[ch] ||
                               frame.addr == ddc_pkg::ADDR_ALL);
        // Masked channels behave as if the pin were low
        assign doUpdate[ch] = q.written[ch] && (q.mask[ch] || !loadHigh);
        // A new write in the update cycle keeps the flag set
        assign writtenNext[ch] = writeHit[ch] | (q.written[ch] & ~doUpdate[ch]);
        assign inputNext[ch]   = writeHit[ch] ? newCode : q.inputCode[ch];
        assign dacNext[ch]     = doUpdate[ch] ? q.inputCode[ch] : q.dacCode[ch];
    end

    always_comb begin
        d           = q;
        d.loadSync  = {q.loadSync[0], loadPinN};
        d.written   = writtenNext;
        d.inputCode = inputNext;
        d.dacCode   = dacNext;
        if (frameValid && frame.cmd == ddc_pkg::CMD_LOAD_MASK) begin
            d.mask = frame.data[ddc_pkg::MASK_LSB +: ddc_pkg::CHANNELS];
        end
        if (frameValid && frame.cmd == ddc_pkg::CMD_REF_SETUP) begin
            d.refEn = frame.data[ddc_pkg::REF_BIT];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{loadSync: 2'h3, mask: ddc_pkg::MASK_RESET,
                   refEn: ddc_pkg::REF_RESET,
                   written: '0, inputCode: '0, dacCode: '0};
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign dacCode   = q.dacCode;
    assign loadMask  = q.mask;
    assign refEnable = q.refEn;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_input_only_frame: assert property (
        (clkEn && !(frameValid && frame.cmd == ddc_pkg::CMD_WRITE_INPUT))
        |=> $stable(q.inputCode))
        else $error("input register changed without a write frame");

    a_hold_pin_high: assert property (
        (clkEn && loadHigh && !q.mask[0]) |=> $stable(q.dacCode[0]))
        else $error("channel A code changed while load pin high");

    a_pin_low_load: assert property (
        (clkEn && !loadHigh && q.written[1]) |=> (q.dacCode[1] == $past(q.inputCode[1])))
        else $error("channel B not loaded while load pin low");

    a_no_stale_update: assert property (
        (clkEn && !q.written[0] && !q.written[1]) |=> $stable(q.dacCode))
        else $error("code register updated without a new write");

    a_sync_update: assert property (
        (clkEn && writeHit[0]) ##1 (clkEn && !loadHigh)
        |=> (q.dacCode[0] == $past(newCode, 2)))
        else $error("synchronous update missed after frame end");

    a_mask_forces: assert property (
        (clkEn && loadHigh && q.mask[1] && q.written[1])
        |=> (q.dacCode[1] == $past(q.inputCode[1]) && !q.written[1]))
        else $error("masked channel B not updated with pin high");

    a_mask_setup: assert property (
        (clkEn && frameValid && frame.cmd == ddc_pkg::CMD_LOAD_MASK)
        |=> (q.mask == $past(frame.data[1:0])))
        else $error("load mask not taken from low data bits");

    a_ref_setup: assert property (
        (clkEn && frameValid && frame.cmd == ddc_pkg::CMD_REF_SETUP)
        |=> (q.refEn == $past(frame.data[0])))
        else $error("reference enable not taken from bit zero");

    a_flag_set_wins: assert property (
        (clkEn && writeHit[0] && doUpdate[0]) |=> q.written[0])
        else $error("written flag lost on write during update");

    // Per-channel mirrors of the update checks above
    a_hold_pin_b: assert property (
        (clkEn && loadHigh && !q.mask[1]) |=> $stable(q.dacCode[1]))
        else $error("channel B code changed while load pin high");

    a_pin_low_a: assert property (
        (clkEn && !loadHigh && q.written[0]) |=> (q.dacCode[0] == $past(q.inputCode[0])))
        else $error("channel A not loaded while load pin low");

    a_sync_update_b: assert property (
        (clkEn && writeHit[1]) ##1 (clkEn && !loadHigh)
        |=> (q.dacCode[1] == $past(newCode, 2)))
        else $error("synchronous update of channel B missed");

    a_mask_forces_a: assert property (
        (clkEn && loadHigh && q.mask[0] && q.written[0] && !writeHit[0])
        |=> (q.dacCode[0] == $past(q.inputCode[0]) && !q.written[0]))
        else $error("masked channel A not updated with pin high");

    a_stale_code_a: assert property (
        (clkEn && !q.written[0]) |=> $stable(q.dacCode[0]))
        else $error("channel A updated without a new write");

    a_stale_code_b: assert property (
        (clkEn && !q.written[1]) |=> $stable(q.dacCode[1]))
        else $error("channel B updated without a new write");

    // Input registers and written flags
    a_input_write_a: assert property (
        (clkEn && writeHit[0]) |=> (q.inputCode[0] == $past(newCode) && q.written[0]))
        else $error("channel A input register not written");

    a_input_write_b: assert property (
        (clkEn && writeHit[1]) |=> (q.inputCode[1] == $past(newCode) && q.written[1]))
        else $error("channel B input register not written");

    a_reserved_addr: assert property (
        (frameValid && frame.addr != ddc_pkg::CH_ADDR[0] && frame.addr != ddc_pkg::CH_ADDR[1]
         && frame.addr != ddc_pkg::ADDR_ALL) |-> (writeHit == 2'h0))
        else $error("reserved address wrote an input register");

    a_flag_clears_a: assert property (
        (clkEn && doUpdate[0] && !writeHit[0]) |=> !q.written[0])
        else $error("written flag of channel A kept after update");

    a_flag_clears_b: assert property (
        (clkEn && doUpdate[1] && !writeHit[1]) |=> !q.written[1])
        else $error("written flag of channel B kept after update");

    // Control registers change only on their own setup frames
    a_mask_stable: assert property (
        (clkEn && !(frameValid && frame.cmd == ddc_pkg::CMD_LOAD_MASK)) |=> $stable(q.mask))
        else $error("load mask changed without a setup frame");

    a_ref_stable: assert property (
        (clkEn && !(frameValid && frame.cmd == ddc_pkg::CMD_REF_SETUP)) |=> $stable(q.refEn))
        else $error("reference enable changed without a setup frame");

    c_async_load: cover property (clkEn && $fell(loadHigh) && q.written[0] && q.written[1]);
    c_masked_update: cover property (clkEn && loadHigh && q.mask[0] && doUpdate[0]);
    c_ref_on: cover property ($rose(q.refEn));
endmodule
`default_nettype wire

// >>> testbench/ddc_host_model.sv
// Host serial port model that drives frame sync, serial clock and serial data
`default_nettype none
module ddc_host_model (
    // Clock
    input  wire logic mclk,
    // Serial pins
    output logic      frameSyncN,
    output logic      serialClk,
    output logic      serialData
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        frameSyncN = 1'b1;
        serialClk  = 1'b0;
        serialData = 1'b0;
    end

    // Sends the leading nFalls bits of a word, clock idle low between bytes
    task automatic send(input logic [23:0] word, input int nFalls);
        frameSyncN <= 1'b0;
        repeat (8) @(posedge mclk);
        for (int i = 23; i >= 24 - nFalls; i--) begin
            serialData <= word[i];
            serialClk  <= 1'b1;
            repeat (8) @(posedge mclk);
            serialClk <= 1'b0;
            repeat (8) @(posedge mclk);
            if (i % 8 == 0) repeat (16) @(posedge mclk);
        end
        frameSyncN <= 1'b1;
        // Released data line shows no stale value
        serialData <= ~serialData;
        repeat (8) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_ddc_load_ctrl.sv
// Self-checking bench of the load pin, load mask and reference control
`default_nettype none
module tb_ddc_load_ctrl;
    timeunit 1ns;
    timeprecision 1ns;

    logic             mclk;
    logic             arst_n;
    logic             clkEn;
    logic             loadPinN;
    logic             frameSyncN;
    logic             serialClk;
    logic             serialData;
    logic [1:0][15:0] dacCode;
    logic [1:0]       loadMask;
    logic             refEnable;
    int               err_count = 0;
    int               n_checks  = 0;

    ddc_host_model ddc_host_model_i (
        .mclk       (mclk),
        .frameSyncN (frameSyncN),
        .serialClk  (serialClk),
        .serialData (serialData)
    );

    ddc_load_ctrl #(.DATA_W(16)) ddc_load_ctrl_i (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .clkEn      (clkEn),
        .frameSyncN (frameSyncN),
        .serialClk  (serialClk),
        .serialData (serialData),
        .loadPinN   (loadPinN),
        .dacCode    (dacCode),
        .loadMask   (loadMask),
        .refEnable  (refEnable)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole frame with both don't-care bits set
    task automatic wr(input logic [2:0] cmd, input logic [2:0] addr, input logic [15:0] data);
        ddc_host_model_i.send({2'h3, cmd, addr, data}, 24);
        repeat (8) @(posedge mclk);
    endtask

    task automatic setPin(input logic level);
        loadPinN <= level;
        repeat (6) @(posedge mclk);
    endtask

    task automatic t_reset();
        chk("code A", dacCode[0], 16'h0000);
        chk("code B", dacCode[1], 16'h0000);
        chk("mask", {14'h0, loadMask}, 16'h0000);
        chk("ref", {15'h0, refEnable}, 16'h0000);
    endtask

    task automatic t_async();
        wr(ddc_pkg::CMD_WRITE_INPUT, 3'h0, 16'h1234);
        wr(ddc_pkg::CMD_WRITE_INPUT, 3'h1, 16'h5678);
        chk("held A", dacCode[0], 16'h0000);
        chk("held B", dacCode[1], 16'h0000);
        setPin(1'b0);
        chk("loaded A", dacCode[0], 16'h1234);
        chk("loaded B", dacCode[1], 16'h5678);
        setPin(1'b1);
    endtask

    task automatic t_sync();
        wr(ddc_pkg::CMD_WRITE_INPUT, 3'h0, 16'h4321);
        chk("pending A", dacCode[0], 16'h1234);
        setPin(1'b0);
        wr(ddc_pkg::CMD_WRITE_INPUT, 3'h1, 16'hFFFF);
        chk("sync B", dacCode[1], 16'hFFFF);
        chk("untouched A", dacCode[0], 16'h4321);
        ddc_host_model_i.send({2'h0, ddc_pkg::CMD_WRITE_INPUT, 3'h1, 16'h0001}, 23);
        ddc_host_model_i.send({2'h0, ddc_pkg::CMD_REF_SETUP, 3'h0, 16'h0001}, 23);
        repeat (8) @(posedge mclk);
        chk("aborted B", dacCode[1], 16'hFFFF);
        chk("aborted ref", {15'h0, refEnable}, 16'h0000);
        setPin(1'b1);
    endtask

    task automatic t_mask();
        wr(ddc_pkg::CMD_LOAD_MASK, 3'h7, 16'hFFFD);
        chk("mask set", {14'h0, loadMask}, 16'h0001);
        wr(ddc_pkg::CMD_WRITE_INPUT, ddc_pkg::ADDR_ALL, 16'h8001);
        chk("masked A", dacCode[0], 16'h8001);
        chk("pin B", dacCode[1], 16'hFFFF);
        setPin(1'b0);
        chk("late B", dacCode[1], 16'h8001);
        setPin(1'b1);
        wr(ddc_pkg::CMD_LOAD_MASK, 3'h2, 16'h0002);
        chk("mask B", {14'h0, loadMask}, 16'h0002);
    endtask

    task automatic t_ref();
        // A frame sent while the clock enable is low must leave no trace
        clkEn <= 1'b0;
        wr(ddc_pkg::CMD_REF_SETUP, 3'h0, 16'h0001);
        clkEn <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("frozen ref", {15'h0, refEnable}, 16'h0000);
        wr(ddc_pkg::CMD_REF_SETUP, 3'h5, 16'hFFFF);
        chk("ref on", {15'h0, refEnable}, 16'h0001);
        wr(ddc_pkg::CMD_REF_SETUP, 3'h2, 16'hFFFE);
        chk("ref off", {15'h0, refEnable}, 16'h0000);
    endtask

    initial begin
        arst_n   = 1'b0;
        clkEn    = 1'b1;
        loadPinN = 1'b1;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_async();
        t_sync();
        t_mask();
        t_ref();
        summarize();
    end

    // Cuts a hang short well beyond the expected run of about 5500 cycles
    initial begin
        repeat (30000) @(posedge mclk);
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
